// File: design/sps_params.svh
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH

// Port population: one upstream, three downstream, one lane each
`define SPS_NUM_PORTS 4
`define SPS_NUM_DOWN 3
`define SPS_UP_PORT 2'h0
`define SPS_LANE_RATE_MBPS 2500
`define SPS_SPEED_2G5 4'h1
`define SPS_WIDTH_X1 6'h01

// General purpose pin slots (pin numbers 0, 1, 2, 7, 9)
`define SPS_NUM_GPIO 5
`define SPS_GPIO_P0 0
`define SPS_GPIO_P1 1
`define SPS_GPIO_P2 2
`define SPS_GPIO_P7 3
`define SPS_GPIO_P9 4

// Downstream port reset request slots
`define SPS_RST_PORT2 0
`define SPS_RST_PORT3 1
`define SPS_RST_PORT4 2

// Synchroniser slots for external inputs
`define SPS_SYNC_WIDTH 8
`define SPS_SYNC_FUND 7
`define SPS_SYNC_CCLK_DOWN 6
`define SPS_SYNC_CCLK_UP 5
`define SPS_SYNC_RESET_VAL 8'h00

// Capability offsets in configuration space
`define SPS_SUBSYS_CAP_OFFSET 8'hC8
`define SPS_SN_CAP_OFFSET 12'h180
`define SPS_PTR_NULL_STD 8'h00
`define SPS_PTR_NULL_EXT 12'h000
`define SPS_WORD_ZERO 32'h0000_0000

`endif

// File: design/sps_pkg.sv
package sps_pkg;

    typedef enum logic [2:0] {
        SPS_ST_RESET = 3'b001,
        SPS_ST_STRAP = 3'b010,
        SPS_ST_RUN = 3'b100
    } sps_state_t;

    typedef enum logic [2:0] {
        SPS_CAP_SUBSYS_IDS = 3'h0,
        SPS_CAP_SN_LOW = 3'h1,
        SPS_CAP_SN_HIGH = 3'h2,
        SPS_CAP_SUBSYS_NEXT = 3'h3,
        SPS_CAP_SN_NEXT = 3'h4,
        SPS_CAP_STD_LINK = 3'h5,
        SPS_CAP_EXT_LINK = 3'h6
    } sps_cap_target_t;

    typedef struct packed {
        logic [4:0] dir_out;
        logic [4:0] irq_en;
        logic [4:0] alt_sel;
        logic [4:0] out_val;
    } sps_gpio_cfg_t;

    typedef struct packed {
        logic valid;
        logic [1:0] port;
        logic value;
    } sps_sclk_wr_t;

    typedef struct packed {
        logic valid;
        sps_cap_target_t target;
        logic [31:0] data;
    } sps_cap_load_t;

    typedef struct packed {
        logic [2:0] rsvd;
        logic slot_clock;
        logic [1:0] rsvd_low;
        logic [5:0] width;
        logic [3:0] speed;
    } sps_link_status_t;

    typedef struct packed {
        logic subsys_present;
        logic sn_present;
        logic [31:0] subsystem_ids_reg;
        logic [31:0] serial_number_low_word;
        logic [31:0] serial_number_high_word;
        logic [7:0] subsys_next_capability_pointer;
        logic [11:0] sn_next_capability_pointer;
        logic [7:0] std_link_pointer;
        logic [11:0] ext_link_pointer;
    } sps_cap_view_t;

endpackage : sps_pkg

// File: design/sps_pin_sync.sv
`timescale 1ns/1ps
`include "sps_params.svh"

module sps_pin_sync #(
    parameter int WIDTH = `SPS_SYNC_WIDTH,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Asynchronous levels and their filtered copies
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] mid_reg;
    logic [WIDTH-1:0] last_reg;
    logic [WIDTH-1:0] level_next;

    // A change is accepted only once the second and third stages agree
    always_comb begin
        level_next = level_out;
        for (int i = 0; i < WIDTH; i++) begin
            if (mid_reg[i] == last_reg[i]) begin
                level_next[i] = last_reg[i];
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_reg <= RESET_VAL;
            mid_reg <= RESET_VAL;
            last_reg <= RESET_VAL;
            level_out <= RESET_VAL;
        end else if (ce_in) begin
            meta_reg <= async_in;
            mid_reg <= meta_reg;
            last_reg <= mid_reg;
            level_out <= level_next;
        end
    end

endmodule : sps_pin_sync

// File: design/sps_top.sv
//
// Overview of operation
// - Downstream strap seeds every downstream slot clock bit.
// - Software may overwrite downstream slot clock bits.
// - Upstream strap seeds upstream slot clock bit.
// - Software may overwrite upstream slot clock bit.
// - Low fundamental reset clears slot clocks, pin drives, capabilities, starts sequence.
// - Names ending _n assert low, others high.
// - Pin 0 alternate drives port two reset.
// - Pin 1 alternate drives port four reset.
// - Pin 9 alternate drives port three reset.
// - Pin 2 alternate samples expander interrupt zero.
// - Pin 7 alternate drives general event output.
// - Five pins: input, output, interrupt, alternate.
// - Subsystem ID capability hidden until loaded, linked.
// - Serial number capability hidden until loaded, linked.
// - Four single-lane ports at 2.5 Gbps.
//
`timescale 1ns/1ps
`include "sps_params.svh"

module sps_top #(
    parameter int NUM_PORTS = `SPS_NUM_PORTS,
    parameter int NUM_GPIO = `SPS_NUM_GPIO,
    parameter int LANE_RATE_MBPS = `SPS_LANE_RATE_MBPS
) (
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // System pins
    input wire logic fundamental_reset_n_in,
    input wire logic common_clock_down_strap_in,
    input wire logic common_clock_up_strap_in,
    // General purpose pins
    input wire logic [4:0] gpio_pin_in,
    output logic [4:0] gpio_pin_out,
    output logic [4:0] gpio_pin_oe_out,
    // General purpose pin configuration and status
    input wire sps_pkg::sps_gpio_cfg_t gpio_cfg_in,
    output logic [4:0] gpio_level_out,
    output logic [4:0] gpio_irq_event_out,
    // Alternate function sources and sinks
    input wire logic [2:0] port_reset_req_in,
    input wire logic event_req_in,
    output logic expander_irq0_out,
    // Slot clock overrides and link status
    input wire sps_pkg::sps_sclk_wr_t sclk_wr_in,
    output sps_pkg::sps_link_status_t [3:0] port_link_status_reg_out,
    output logic fund_reset_active_out,
    // Capability configuration
    input wire sps_pkg::sps_cap_load_t cap_load_in,
    output sps_pkg::sps_cap_view_t cap_view_out
);
    import sps_pkg::*;

    function automatic sps_link_status_t link_status(input logic sclk);
        sps_link_status_t s;
        s = '0;
        s.speed = `SPS_SPEED_2G5;
        s.width = `SPS_WIDTH_X1;
        s.slot_clock = sclk;
        return s;
    endfunction : link_status

    function automatic logic cap_linked(input logic loaded, input logic [11:0] ptr,
                                        input logic [11:0] offset);
        return loaded && (ptr == offset);
    endfunction : cap_linked

    // Synchronised external inputs
    logic [`SPS_SYNC_WIDTH-1:0] sync_level;
    logic fund_n_sync;
    logic cclk_down_sync;
    logic cclk_up_sync;
    logic [4:0] pin_sync;

    sps_pin_sync #(
        .WIDTH(`SPS_SYNC_WIDTH),
        .RESET_VAL(`SPS_SYNC_RESET_VAL)
    ) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .async_in({fundamental_reset_n_in, common_clock_down_strap_in,
                   common_clock_up_strap_in, gpio_pin_in}),
        .level_out(sync_level)
    );

    assign fund_n_sync = sync_level[`SPS_SYNC_FUND];
    assign cclk_down_sync = sync_level[`SPS_SYNC_CCLK_DOWN];
    assign cclk_up_sync = sync_level[`SPS_SYNC_CCLK_UP];
    assign pin_sync = sync_level[4:0];

    // Reset sequence state
    sps_state_t state_reg;
    sps_state_t state_next;
    logic fund_active_reg;
    logic fund_active_next;

    // The synchroniser resets to zero, so the pin counts as asserted until proven high
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SPS_ST_RESET: begin
                if (fund_n_sync) begin
                    state_next = SPS_ST_STRAP;
                end
            end
            SPS_ST_STRAP: begin
                state_next = SPS_ST_RUN;
            end
            SPS_ST_RUN: begin
                state_next = SPS_ST_RUN;
            end
            default: begin
                state_next = SPS_ST_RESET;
            end
        endcase
        if (!fund_n_sync) begin
            state_next = SPS_ST_RESET;
        end
        fund_active_next = (state_next == SPS_ST_RESET);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= SPS_ST_RESET;
            fund_active_reg <= 1'b1;
        end else if (ce_in) begin
            state_reg <= state_next;
            fund_active_reg <= fund_active_next;
        end
    end

    // Slot clock bits: index 0 upstream, 1..3 downstream
    logic [3:0] sclk_reg;
    logic [3:0] sclk_next;
    sps_link_status_t [3:0] link_next;

    always_comb begin
        sclk_next = sclk_reg;
        if (state_reg == SPS_ST_RESET) begin
            sclk_next = '0;
        end else if (state_reg == SPS_ST_STRAP) begin
            for (int p = 0; p < `SPS_NUM_PORTS; p++) begin
                sclk_next[p] = cclk_down_sync;
            end
            sclk_next[`SPS_UP_PORT] = cclk_up_sync;
        end else if (sclk_wr_in.valid) begin
            // Upstream slot lives at index zero, downstream at their port slots
            sclk_next[sclk_wr_in.port] = sclk_wr_in.value;
        end
        for (int p = 0; p < `SPS_NUM_PORTS; p++) begin
            link_next[p] = link_status(sclk_next[p]);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sclk_reg <= '0;
            port_link_status_reg_out <= '0;
        end else if (ce_in) begin
            sclk_reg <= sclk_next;
            port_link_status_reg_out <= link_next;
        end
    end

    // General purpose pins
    sps_gpio_cfg_t cfg_eff;
    logic [4:0] alt_val;
    logic [4:0] alt_drives;
    logic [4:0] pin_out_next;
    logic [4:0] pin_oe_next;
    logic [4:0] prev_level_reg;
    logic [4:0] irq_next;
    logic exp_irq_next;
    logic [2:0] port_rst_assert;

    always_comb begin
        // Until the sequence completes every pin is a plain input
        cfg_eff = (state_reg == SPS_ST_RUN) ? gpio_cfg_in : '0;
        port_rst_assert = port_reset_req_in | {3{fund_active_reg}};
        alt_val = '1;
        alt_val[`SPS_GPIO_P0] = ~port_rst_assert[`SPS_RST_PORT2];
        alt_val[`SPS_GPIO_P1] = ~port_rst_assert[`SPS_RST_PORT4];
        alt_val[`SPS_GPIO_P9] = ~port_rst_assert[`SPS_RST_PORT3];
        alt_val[`SPS_GPIO_P7] = ~event_req_in;
        alt_drives = '1;
        alt_drives[`SPS_GPIO_P2] = 1'b0;
        for (int g = 0; g < `SPS_NUM_GPIO; g++) begin
            if (cfg_eff.alt_sel[g]) begin
                pin_oe_next[g] = alt_drives[g];
                pin_out_next[g] = alt_val[g];
            end else begin
                // An interrupt input never drives, whatever the direction bit says
                pin_oe_next[g] = cfg_eff.dir_out[g] & ~cfg_eff.irq_en[g];
                pin_out_next[g] = cfg_eff.out_val[g];
            end
        end
        irq_next = cfg_eff.irq_en & ~cfg_eff.alt_sel & pin_sync & ~prev_level_reg;
        exp_irq_next = cfg_eff.alt_sel[`SPS_GPIO_P2] & ~pin_sync[`SPS_GPIO_P2];
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gpio_pin_out <= '0;
            gpio_pin_oe_out <= '0;
            gpio_level_out <= '0;
            gpio_irq_event_out <= '0;
            prev_level_reg <= '0;
            expander_irq0_out <= 1'b0;
            fund_reset_active_out <= 1'b1;
        end else if (ce_in) begin
            gpio_pin_out <= pin_out_next;
            gpio_pin_oe_out <= pin_oe_next;
            gpio_level_out <= pin_sync;
            gpio_irq_event_out <= irq_next;
            prev_level_reg <= pin_sync;
            expander_irq0_out <= exp_irq_next;
            fund_reset_active_out <= fund_active_next;
        end
    end

    // Capability structures
    sps_cap_view_t cap_reg;
    sps_cap_view_t cap_next;
    logic ids_loaded_reg;
    logic ids_loaded_next;
    logic sn_low_loaded_reg;
    logic sn_low_loaded_next;
    logic sn_high_loaded_reg;
    logic sn_high_loaded_next;

    always_comb begin
        cap_next = cap_reg;
        ids_loaded_next = ids_loaded_reg;
        sn_low_loaded_next = sn_low_loaded_reg;
        sn_high_loaded_next = sn_high_loaded_reg;
        if (state_reg == SPS_ST_RESET) begin
            cap_next = '0;
            ids_loaded_next = 1'b0;
            sn_low_loaded_next = 1'b0;
            sn_high_loaded_next = 1'b0;
        end else if (cap_load_in.valid) begin
            case (cap_load_in.target)
                SPS_CAP_SUBSYS_IDS: begin
                    cap_next.subsystem_ids_reg = cap_load_in.data;
                    ids_loaded_next = 1'b1;
                end
                SPS_CAP_SN_LOW: begin
                    cap_next.serial_number_low_word = cap_load_in.data;
                    sn_low_loaded_next = 1'b1;
                end
                SPS_CAP_SN_HIGH: begin
                    cap_next.serial_number_high_word = cap_load_in.data;
                    sn_high_loaded_next = 1'b1;
                end
                SPS_CAP_SUBSYS_NEXT: begin
                    cap_next.subsys_next_capability_pointer = cap_load_in.data[7:0];
                end
                SPS_CAP_SN_NEXT: begin
                    cap_next.sn_next_capability_pointer = cap_load_in.data[11:0];
                end
                SPS_CAP_STD_LINK: begin
                    cap_next.std_link_pointer = cap_load_in.data[7:0];
                end
                SPS_CAP_EXT_LINK: begin
                    cap_next.ext_link_pointer = cap_load_in.data[11:0];
                end
                default: begin
                    cap_next = cap_reg;
                end
            endcase
        end
        // Visible only once the fields are loaded and another capability points here
        cap_next.subsys_present = cap_linked(ids_loaded_next,
            {4'h0, cap_next.std_link_pointer}, {4'h0, `SPS_SUBSYS_CAP_OFFSET});
        cap_next.sn_present = cap_linked(sn_low_loaded_next && sn_high_loaded_next,
            cap_next.ext_link_pointer, `SPS_SN_CAP_OFFSET);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cap_reg <= '0;
            ids_loaded_reg <= 1'b0;
            sn_low_loaded_reg <= 1'b0;
            sn_high_loaded_reg <= 1'b0;
            cap_view_out <= '0;
        end else if (ce_in) begin
            cap_reg <= cap_next;
            ids_loaded_reg <= ids_loaded_next;
            sn_low_loaded_reg <= sn_low_loaded_next;
            sn_high_loaded_reg <= sn_high_loaded_next;
            cap_view_out <= cap_next;
        end
    end

endmodule : sps_top

// File: bench/sps_top_chk.sv
`timescale 1ns/1ps
`include "sps_params.svh"

module sps_top_chk (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Pins and controls
    input wire logic fundamental_reset_n_in,
    input wire logic common_clock_down_strap_in,
    input wire logic common_clock_up_strap_in,
    input wire sps_pkg::sps_gpio_cfg_t gpio_cfg_in,
    input wire logic [2:0] port_reset_req_in,
    input wire logic event_req_in,
    input wire sps_pkg::sps_sclk_wr_t sclk_wr_in,
    // Observed outputs
    input wire logic [4:0] gpio_pin_out,
    input wire logic [4:0] gpio_pin_oe_out,
    input wire sps_pkg::sps_link_status_t [3:0] port_link_status_reg_out,
    input wire logic fund_reset_active_out,
    input wire sps_pkg::sps_cap_view_t cap_view_out
);
    import sps_pkg::*;
    logic [2:0] hi_cnt_reg;
    logic [2:0] hi_cnt_next;
    logic fund_q_reg;
    logic fund_q_next;
    logic run_ok;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    always_comb begin
        hi_cnt_next = fundamental_reset_n_in ? hi_cnt_reg + {2'h0, hi_cnt_reg != 3'h7} : 3'h0;
        fund_q_next = fund_reset_active_out;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hi_cnt_reg <= 3'h0;
            fund_q_reg <= 1'b1;
        end else begin
            hi_cnt_reg <= hi_cnt_next;
            fund_q_reg <= fund_q_next;
        end
    end

    // A pin drop needs several edges to reach the sequencer, so a long high run means RUN holds
    assign run_ok = ce_in && hi_cnt_reg == 3'h7 && !fund_reset_active_out && !fund_q_reg;

    a_sclk_write_lands: assert property (run_ok && sclk_wr_in.valid |=>
        port_link_status_reg_out[$past(sclk_wr_in.port)].slot_clock == $past(sclk_wr_in.value))
        else $error("slot clock write not applied");
    a_strap_seed_load: assert property ($fell(fund_reset_active_out) |=>
        port_link_status_reg_out[0].slot_clock == common_clock_up_strap_in &&
        port_link_status_reg_out[1].slot_clock == common_clock_down_strap_in &&
        port_link_status_reg_out[3].slot_clock == common_clock_down_strap_in)
        else $error("strap not seeded");
    a_port2_reset_alt: assert property (run_ok && gpio_cfg_in.alt_sel[0] |=>
        gpio_pin_oe_out[0] && gpio_pin_out[0] == !$past(port_reset_req_in[0]))
        else $error("port two reset pin wrong");
    a_port4_reset_alt: assert property (run_ok && gpio_cfg_in.alt_sel[1] |=>
        gpio_pin_oe_out[1] && gpio_pin_out[1] == !$past(port_reset_req_in[2]))
        else $error("port four reset pin wrong");
    a_port3_reset_alt: assert property (run_ok && gpio_cfg_in.alt_sel[4] |=>
        gpio_pin_oe_out[4] && gpio_pin_out[4] == !$past(port_reset_req_in[1]))
        else $error("port three reset pin wrong");
    a_event_out_alt: assert property (run_ok && gpio_cfg_in.alt_sel[3] |=>
        gpio_pin_oe_out[3] && gpio_pin_out[3] == !$past(event_req_in))
        else $error("event pin wrong");
    a_expander_pin_input: assert property (run_ok && gpio_cfg_in.alt_sel[2] |=>
        !gpio_pin_oe_out[2])
        else $error("expander pin driven");
    a_reset_holds_inputs: assert property (fund_reset_active_out [*2] |->
        gpio_pin_oe_out == 5'h00 && !cap_view_out.subsys_present && !cap_view_out.sn_present)
        else $error("state kept in reset");
    a_fund_reset_reach: assert property (!fundamental_reset_n_in [*8] |->
        fund_reset_active_out)
        else $error("fundamental reset not entered");
    a_subsys_linked: assert property (cap_view_out.subsys_present |->
        cap_view_out.std_link_pointer == `SPS_SUBSYS_CAP_OFFSET)
        else $error("subsystem id shown unlinked");
    a_sn_linked: assert property (cap_view_out.sn_present |->
        cap_view_out.ext_link_pointer == `SPS_SN_CAP_OFFSET)
        else $error("serial number shown unlinked");

    c_sclk_write: cover property (run_ok && sclk_wr_in.valid);
    c_strap_seed: cover property ($fell(fund_reset_active_out));
    c_caps_shown: cover property (cap_view_out.subsys_present && cap_view_out.sn_present);
endmodule : sps_top_chk

bind sps_top sps_top_chk i_sps_top_chk (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .fundamental_reset_n_in(fundamental_reset_n_in),
    .common_clock_down_strap_in(common_clock_down_strap_in),
    .common_clock_up_strap_in(common_clock_up_strap_in),
    .gpio_cfg_in(gpio_cfg_in), .port_reset_req_in(port_reset_req_in),
    .event_req_in(event_req_in), .sclk_wr_in(sclk_wr_in),
    .gpio_pin_out(gpio_pin_out), .gpio_pin_oe_out(gpio_pin_oe_out),
    .port_link_status_reg_out(port_link_status_reg_out),
    .fund_reset_active_out(fund_reset_active_out), .cap_view_out(cap_view_out)
);

// File: bench/sps_far_model.sv
`timescale 1ns/1ps

module sps_far_model (
    // Device side of the pins
    input wire logic [4:0] pin_out_in,
    input wire logic [4:0] pin_oe_in,
    // Board side: expander and other drivers
    input wire logic [4:0] far_drive_in,
    input wire logic [4:0] far_en_in,
    output logic [4:0] pin_level_out
);
    // Released pins rest at the board pull-up, so a low always means someone asserts it
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pin_level_out[i] = pin_oe_in[i] ? pin_out_in[i] :
                (far_en_in[i] ? far_drive_in[i] : 1'b1);
        end
    end
endmodule : sps_far_model

// File: bench/strap_pin_and_capability_setup_test.sv
`timescale 1ns/1ps
`include "sps_params.svh"

module strap_pin_and_capability_setup_test;
    import sps_pkg::*;
    logic clk_in, rst_in, ce_in, fund_n, strap_dn, strap_up, event_req, exp_irq, fund_act;
    logic [2:0] rst_req;
    logic [4:0] pin_level, pin_out, pin_oe, level, irq_evt, far_drive, far_en;
    logic [31:0] rnd;
    sps_gpio_cfg_t cfg;
    sps_sclk_wr_t sclk_wr;
    sps_cap_load_t cap_load;
    sps_link_status_t [3:0] lstat;
    sps_cap_view_t view;
    logic sc_exp [4];
    int n_errors = 0;
    int check_count = 0;

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    sps_top i_sps_top (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .fundamental_reset_n_in(fund_n), .common_clock_down_strap_in(strap_dn),
        .common_clock_up_strap_in(strap_up), .gpio_pin_in(pin_level),
        .gpio_pin_out(pin_out), .gpio_pin_oe_out(pin_oe), .gpio_cfg_in(cfg),
        .gpio_level_out(level), .gpio_irq_event_out(irq_evt),
        .port_reset_req_in(rst_req), .event_req_in(event_req),
        .expander_irq0_out(exp_irq), .sclk_wr_in(sclk_wr),
        .port_link_status_reg_out(lstat), .fund_reset_active_out(fund_act),
        .cap_load_in(cap_load), .cap_view_out(view));

    sps_far_model i_sps_far_model (.pin_out_in(pin_out), .pin_oe_in(pin_oe),
        .far_drive_in(far_drive), .far_en_in(far_en), .pin_level_out(pin_level));

    task automatic check(input logic [159:0] seen, input logic [159:0] expected);
        check_count++;
        if (seen !== expected) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, expected);
        end
    endtask : check

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic guard(input bit ok);
        if (!ok) begin
            n_errors++;
            give_verdict();
        end
    endtask : guard

    task automatic wait_run;
        int i;
        for (i = 0; i < 40 && fund_act !== 1'b0; i++) @(negedge clk_in);
        guard(i < 40);
        repeat (2) @(negedge clk_in);
    endtask : wait_run

    task automatic check_links;
        for (int p = 0; p < 4; p++) begin
            check(lstat[p], {3'h0, sc_exp[p], 2'h0, `SPS_WIDTH_X1, `SPS_SPEED_2G5});
        end
    endtask : check_links

    task automatic cap(input sps_cap_target_t t, input logic [31:0] d);
        cap_load = {1'b1, t, d};
        @(negedge clk_in);
        cap_load.valid = 1'b0;
        @(negedge clk_in);
    endtask : cap

    // Expected {oe, out}; the expander pin is never driven in its alternate role
    function automatic logic [9:0] gpio_exp(sps_gpio_cfg_t c, logic [2:0] rq, logic ev);
        logic [4:0] oe;
        logic [4:0] alt_o;
        alt_o = {~rq[1], ~ev, 1'b0, ~rq[2], ~rq[0]};
        oe = (c.dir_out & ~c.irq_en & ~c.alt_sel) | (c.alt_sel & 5'h1B);
        return {oe, ((c.alt_sel & alt_o) | (~c.alt_sel & c.out_val)) & oe};
    endfunction : gpio_exp

    task automatic wait_exp(input logic v);
        int i;
        for (i = 0; i < 20 && exp_irq !== v; i++) @(negedge clk_in);
        guard(i < 20);
        check({exp_irq, level[2]}, {v, ~v});
    endtask : wait_exp

    initial begin
        int i;
        rst_in = 1'b1;
        ce_in = 1'b1;
        fund_n = 1'b1;
        strap_dn = 1'b1;
        strap_up = 1'b0;
        event_req = 1'b0;
        rst_req = 3'h0;
        far_drive = 5'h1F;
        far_en = 5'h00;
        cfg = '0;
        sclk_wr = '0;
        cap_load = '0;
        void'($urandom(32'h9DEA));
        repeat (16) @(negedge clk_in);
        rst_in = 1'b0;
        wait_run();
        sc_exp = '{1'b0, 1'b1, 1'b1, 1'b1};
        check_links();
        check(view, '0);
        for (int k = 0; k < 16; k++) begin
            sclk_wr = {1'b1, 2'($urandom_range(3)), 1'($urandom)};
            sc_exp[sclk_wr.port] = sclk_wr.value;
            @(negedge clk_in);
            if (k % 4 == 3) begin
                sclk_wr.valid = 1'b0;
                @(negedge clk_in);
                check_links();
            end
        end
        // Clock enable low must hold back a pending slot clock write
        ce_in = 1'b0;
        sclk_wr = {1'b1, 2'h0, ~sc_exp[0]};
        repeat (3) @(negedge clk_in);
        check_links();
        ce_in = 1'b1;
        sc_exp[0] = sclk_wr.value;
        @(negedge clk_in);
        sclk_wr.valid = 1'b0;
        @(negedge clk_in);
        check_links();
        for (int k = 0; k < 24; k++) begin
            cfg = 20'($urandom);
            if (k < 2) cfg.alt_sel = k ? 5'h1F : 5'h00;
            rst_req = 3'($urandom);
            event_req = 1'($urandom);
            repeat (2) @(negedge clk_in);
            check({pin_oe, pin_out & pin_oe}, gpio_exp(cfg, rst_req, event_req));
        end
        cfg = '0;
        cfg.alt_sel = 5'h04;
        far_en = 5'h04;
        far_drive = 5'h00;
        wait_exp(1'b1);
        far_drive = 5'h1F;
        wait_exp(1'b0);
        cfg = '0;
        cfg.irq_en = 5'h08;
        far_en = 5'h08;
        far_drive = 5'h00;
        repeat (10) @(negedge clk_in);
        far_drive = 5'h1F;
        for (i = 0; i < 20 && irq_evt[3] !== 1'b1; i++) @(negedge clk_in);
        guard(i < 20);
        @(negedge clk_in);
        check({irq_evt, level}, {5'h00, 5'h1F});
        cap(SPS_CAP_STD_LINK, {24'h0, `SPS_SUBSYS_CAP_OFFSET});
        check(view.subsys_present, 1'b0);
        rnd = $urandom;
        cap(SPS_CAP_SUBSYS_IDS, rnd);
        check({view.subsys_present, view.subsystem_ids_reg}, {1'b1, rnd});
        cap(SPS_CAP_SUBSYS_NEXT, 32'h0000_0040);
        check(view.subsys_next_capability_pointer, 8'h40);
        cap(SPS_CAP_EXT_LINK, {20'h0, `SPS_SN_CAP_OFFSET});
        cap(SPS_CAP_SN_LOW, rnd);
        check(view.sn_present, 1'b0);
        cap(SPS_CAP_SN_HIGH, ~rnd);
        cap(SPS_CAP_SN_NEXT, 32'h0000_0100);
        check({view.sn_present, view.serial_number_low_word, view.serial_number_high_word,
            view.subsys_next_capability_pointer, view.sn_next_capability_pointer},
            {1'b1, rnd, ~rnd, 8'h40, 12'h100});
        cfg.alt_sel = 5'h1B;
        rst_req = 3'h0;
        fund_n = 1'b0;
        strap_dn = 1'b0;
        strap_up = 1'b1;
        repeat (12) @(negedge clk_in);
        check({fund_act, pin_oe, view.subsys_present, view.sn_present}, 8'h80);
        cfg = '0;
        fund_n = 1'b1;
        wait_run();
        sc_exp = '{1'b1, 1'b0, 1'b0, 1'b0};
        check_links();
        check(pin_oe, 5'h00);
        give_verdict();
    end
endmodule : strap_pin_and_capability_setup_test
